/* logic/sleep_state_supply_control.sv */
// Sleep-state supply control register bank and supply state decode
// Notes on behaviour
// - Hold bit set keeps converter PWM in sleep
// - Hold bit clear forces PFM; PFM stays PFM
// - LDO sleep-off bit turns LDO off in sleep
// - LDO sleep-off acts only when hold bit clear
// - Converter sleep-off bits 3..0 turn converter off
// - Converter sleep-off acts only when hold clear
// - Wake select restores default voltages on wake
// - Assigned LDO full on while pin one high
// - Pin low: hold clear off, set low power
// - Unassigned LDO ignores pin level entirely
// - Any assignment bit disables voltage-scaling port
// - Core buck voltage from operating or sleep register
// - Pin low with hold: low power unless off
// - External converter voltage follows pin one likewise
// - IO buck on with pin high; pin low: low power if hold set, else off
// - Pin two LDO register mirrors pin one control
// - LDO bit order 3,4,7,8,5,2,1,6, reset zero
// - Assignments cleared by turn-off reset only
// - LDO hold bit keeps full load in sleep
`timescale 1ns/1ns
`default_nettype none
module sleep_state_supply_control (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_general_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_sleep,
   input wire logic i_wake,
   input wire logic i_mux_ctl_pin_one,
   input wire logic i_mux_ctl_pin_two,
   input wire logic [7:0] i_ldo_enabled,
   input wire logic [3:0] i_conv_enabled,
   input wire logic [2:0] i_conv_pfm_mode,
   input wire logic [3:0] i_conv_op_off,
   input wire logic [3:0] i_conv_sleep_volt_off,
   output logic [7:0] o_reg_rdata,
   output logic [7:0] o_ldo_on,
   output logic [7:0] o_ldo_low_power,
   output logic [3:0] o_conv_on,
   output logic [3:0] o_conv_low_power,
   output logic [2:0] o_conv_pfm,
   output logic [3:0] o_conv_use_sleep_voltage,
   output logic o_restore_defaults,
   output logic o_vs_i2c_disable
);
   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      logic [7:0] ldo_hold;
      logic [7:0] res_hold;
      logic [7:0] ldo_off;
      logic [7:0] conv_off;
      logic [7:0] ldo_pin_one;
      logic [7:0] conv_pin_one;
      logic [7:0] ldo_pin_two;
      logic pin_one_s1;
      logic pin_one_s2;
      logic pin_two_s1;
      logic pin_two_s2;
      logic [7:0] rdata;
      logic [7:0] ldo_on;
      logic [7:0] ldo_lp;
      logic [3:0] conv_on;
      logic [3:0] conv_lp;
      logic [2:0] conv_pfm;
      logic [3:0] conv_slv;
      logic restore;
      logic vs_dis;
   } state_type;

   state_type s_r;
   state_type s_nxt;

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic [7:0] masked_write(input logic [7:0] old, input logic [7:0] wd, input logic [7:0] m);
      masked_write = (old & ~m) | (wd & m);
   endfunction : masked_write

   function automatic logic pin_level(input logic a1, input logic a2, input logic p1, input logic p2);
      pin_level = (a1 & p1) | (a2 & p2);
   endfunction : pin_level

   // ****************************************
   // Next state
   // ****************************************
   always_comb
   begin
      logic pin;
      logic hold;
      pin = 1'b0;
      hold = 1'b0;
      s_nxt = s_r;
      s_nxt.pin_one_s1 = i_mux_ctl_pin_one;
      s_nxt.pin_one_s2 = s_r.pin_one_s1;
      s_nxt.pin_two_s1 = i_mux_ctl_pin_two;
      s_nxt.pin_two_s2 = s_r.pin_two_s1;
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            sleep_supply_pkg::ADDR_LDO_HOLD:
               s_nxt.ldo_hold = masked_write(s_r.ldo_hold, i_reg_wdata, sleep_supply_pkg::MASK_FULL);
            sleep_supply_pkg::ADDR_RES_HOLD:
               s_nxt.res_hold = masked_write(s_r.res_hold, i_reg_wdata, sleep_supply_pkg::MASK_RES_HOLD);
            sleep_supply_pkg::ADDR_LDO_SLEEP_OFF:
               s_nxt.ldo_off = masked_write(s_r.ldo_off, i_reg_wdata, sleep_supply_pkg::MASK_FULL);
            sleep_supply_pkg::ADDR_CONV_SLEEP_OFF:
               s_nxt.conv_off = masked_write(s_r.conv_off, i_reg_wdata, sleep_supply_pkg::MASK_CONV_SLEEP_OFF);
            sleep_supply_pkg::ADDR_LDO_PIN_ONE:
               s_nxt.ldo_pin_one = masked_write(s_r.ldo_pin_one, i_reg_wdata, sleep_supply_pkg::MASK_FULL);
            sleep_supply_pkg::ADDR_CONV_PIN_ONE:
               s_nxt.conv_pin_one = masked_write(s_r.conv_pin_one, i_reg_wdata, sleep_supply_pkg::MASK_CONV_PIN_ONE);
            sleep_supply_pkg::ADDR_LDO_PIN_TWO:
               s_nxt.ldo_pin_two = masked_write(s_r.ldo_pin_two, i_reg_wdata, sleep_supply_pkg::MASK_FULL);
            default:
            begin
            end
         endcase
      end
      // General reset clears its own domain and leaves the pin assignments alone
      if (i_general_rst)
      begin
         s_nxt.ldo_hold = sleep_supply_pkg::RESET_VALUE;
         s_nxt.res_hold = sleep_supply_pkg::RESET_VALUE;
         s_nxt.ldo_off = sleep_supply_pkg::RESET_VALUE;
         s_nxt.conv_off = sleep_supply_pkg::RESET_VALUE;
      end
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            sleep_supply_pkg::ADDR_LDO_HOLD: s_nxt.rdata = s_r.ldo_hold;
            sleep_supply_pkg::ADDR_RES_HOLD: s_nxt.rdata = s_r.res_hold;
            sleep_supply_pkg::ADDR_LDO_SLEEP_OFF: s_nxt.rdata = s_r.ldo_off;
            sleep_supply_pkg::ADDR_CONV_SLEEP_OFF: s_nxt.rdata = s_r.conv_off;
            sleep_supply_pkg::ADDR_LDO_PIN_ONE: s_nxt.rdata = s_r.ldo_pin_one;
            sleep_supply_pkg::ADDR_CONV_PIN_ONE: s_nxt.rdata = s_r.conv_pin_one;
            sleep_supply_pkg::ADDR_LDO_PIN_TWO: s_nxt.rdata = s_r.ldo_pin_two;
            default: s_nxt.rdata = 8'h00;
         endcase
      end
      // ****************************************
      // LDO state
      // ****************************************
      for (int i = 0; i < sleep_supply_pkg::NUM_LDO; i++)
      begin
         hold = s_r.ldo_hold[i];
         pin = pin_level(s_r.ldo_pin_one[i], s_r.ldo_pin_two[i], s_r.pin_one_s2, s_r.pin_two_s2);
         if (s_r.ldo_pin_one[i] | s_r.ldo_pin_two[i])
         begin
            s_nxt.ldo_on[i] = pin | hold;
            s_nxt.ldo_lp[i] = ~pin & hold;
         end
         else if (i_sleep)
         begin
            s_nxt.ldo_on[i] = i_ldo_enabled[i] & ~(s_r.ldo_off[i] & ~hold);
            s_nxt.ldo_lp[i] = i_ldo_enabled[i] & ~s_r.ldo_off[i] & ~hold;
         end
         else
         begin
            s_nxt.ldo_on[i] = i_ldo_enabled[i];
            s_nxt.ldo_lp[i] = 1'b0;
         end
      end
      // ****************************************
      // Converter state
      // ****************************************
      for (int i = 0; i < sleep_supply_pkg::NUM_CONV; i++)
      begin
         hold = s_r.res_hold[i];
         pin = s_r.pin_one_s2;
         if (s_r.conv_pin_one[i] && i == sleep_supply_pkg::IO_BIT)
         begin
            s_nxt.conv_on[i] = pin | hold;
            s_nxt.conv_lp[i] = ~pin & hold;
            s_nxt.conv_slv[i] = 1'b0;
         end
         else if (s_r.conv_pin_one[i])
         begin
            s_nxt.conv_on[i] = pin ? ~i_conv_op_off[i] : ~i_conv_sleep_volt_off[i];
            s_nxt.conv_lp[i] = ~pin & hold & ~i_conv_sleep_volt_off[i];
            s_nxt.conv_slv[i] = ~pin;
         end
         else if (i_sleep)
         begin
            s_nxt.conv_on[i] = i_conv_enabled[i] & ~(s_r.conv_off[i] & ~hold);
            s_nxt.conv_lp[i] = 1'b0;
            s_nxt.conv_slv[i] = 1'b0;
         end
         else
         begin
            s_nxt.conv_on[i] = i_conv_enabled[i];
            s_nxt.conv_lp[i] = 1'b0;
            s_nxt.conv_slv[i] = 1'b0;
         end
      end
      for (int i = 0; i < sleep_supply_pkg::NUM_PWM; i++)
      begin
         if (i_sleep && !s_r.conv_pin_one[i])
         begin
            s_nxt.conv_pfm[i] = i_conv_pfm_mode[i] | ~s_r.res_hold[i];
         end
         else
         begin
            s_nxt.conv_pfm[i] = i_conv_pfm_mode[i];
         end
      end
      s_nxt.restore = i_wake & s_r.conv_off[sleep_supply_pkg::WAKE_SEL_BIT];
      s_nxt.vs_dis = (|s_r.ldo_pin_one) | (|s_r.conv_pin_one) | (|s_r.ldo_pin_two);
   end

   // ****************************************
   // Registers; asynchronous reset is the turn-off reset
   // ****************************************
   always_ff @(posedge i_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign o_reg_rdata = s_r.rdata;
   assign o_ldo_on = s_r.ldo_on;
   assign o_ldo_low_power = s_r.ldo_lp;
   assign o_conv_on = s_r.conv_on;
   assign o_conv_low_power = s_r.conv_lp;
   assign o_conv_pfm = s_r.conv_pfm;
   assign o_conv_use_sleep_voltage = s_r.conv_slv;
   assign o_restore_defaults = s_r.restore;
   assign o_vs_i2c_disable = s_r.vs_dis;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   a_pwm_hold_kept: assert property (i_sleep && !s_r.conv_pin_one[1] && s_r.res_hold[1]
      && !i_conv_pfm_mode[1] |=> !o_conv_pfm[1]) else $error("core a left PWM despite hold");
   a_pfm_forced: assert property (i_sleep && !s_r.conv_pin_one[2] && !s_r.res_hold[2]
      |=> o_conv_pfm[2]) else $error("core b not forced to PFM");
   a_ldo_sleep_off: assert property (i_sleep && s_r.ldo_off[3] && !s_r.ldo_hold[3]
      && !s_r.ldo_pin_one[3] && !s_r.ldo_pin_two[3] |=> !o_ldo_on[3]) else $error("LDO not off in sleep");
   a_ldo_hold_wins: assert property (i_sleep && s_r.ldo_off[0] && s_r.ldo_hold[0] && i_ldo_enabled[0]
      && !s_r.ldo_pin_one[0] && !s_r.ldo_pin_two[0] |=> o_ldo_on[0] && !o_ldo_low_power[0])
      else $error("LDO hold did not win");
   a_conv_sleep_off: assert property (i_sleep && s_r.conv_off[3] && !s_r.res_hold[3]
      && !s_r.conv_pin_one[3] |=> !o_conv_on[3]) else $error("converter not off in sleep");
   a_wake_restore: assert property (i_wake && s_r.conv_off[7] |=> o_restore_defaults)
      else $error("defaults not restored on wake");
   a_wake_quiet: assert property (!(i_wake && s_r.conv_off[7]) |=> !o_restore_defaults)
      else $error("spurious default restore");
   a_pin_one_ldo: assert property (s_r.ldo_pin_one[7] && s_r.pin_one_s2
      |=> o_ldo_on[7] && !o_ldo_low_power[7]) else $error("assigned LDO not full on");
   a_pin_low_ldo: assert property (s_r.ldo_pin_one[7] && !s_r.ldo_pin_two[7] && !s_r.pin_one_s2
      |=> o_ldo_on[7] == $past(s_r.ldo_hold[7]) && o_ldo_low_power[7] == $past(s_r.ldo_hold[7]))
      else $error("pin low LDO state wrong");
   a_unassigned_ldo: assert property (!s_r.ldo_pin_one[5] && !s_r.ldo_pin_two[5] && !i_sleep
      |=> o_ldo_on[5] == $past(i_ldo_enabled[5])) else $error("unassigned LDO followed pin");
   a_vs_disable: assert property ((|s_r.ldo_pin_one) || (|s_r.conv_pin_one) || (|s_r.ldo_pin_two)
      |=> o_vs_i2c_disable) else $error("voltage scaling port not disabled");
   a_core_volt_sel: assert property (s_r.conv_pin_one[1]
      |=> o_conv_use_sleep_voltage[1] == !$past(s_r.pin_one_s2)) else $error("core a voltage select wrong");
   a_io_pin_high: assert property (s_r.conv_pin_one[0] && s_r.pin_one_s2 |=> o_conv_on[0])
      else $error("IO buck not on with pin high");
   a_pin_two_ldo: assert property (s_r.ldo_pin_two[6] && s_r.pin_two_s2 |=> o_ldo_on[6])
      else $error("pin two LDO not on");
   a_assign_kept: assert property (i_general_rst && !i_reg_wr
      |=> s_r.ldo_pin_one == $past(s_r.ldo_pin_one) && s_r.ldo_off == 8'h00) else $error("reset domains mixed");
   a_reserved_zero: assert property (i_reg_rd && i_reg_addr == sleep_supply_pkg::ADDR_CONV_SLEEP_OFF
      |=> o_reg_rdata[6:5] == 2'h0) else $error("reserved bits read nonzero");

   // ****************************************
   // Sleep-state checks
   // ****************************************
   a_pwm_core_b: assert property (i_sleep && s_r.res_hold[2] && !s_r.conv_pin_one[2]
      && !i_conv_pfm_mode[2] |=> !o_conv_pfm[2])
      else $error("core b left PWM despite hold");
   a_pfm_stays: assert property (i_sleep && i_conv_pfm_mode[0]
      |=> o_conv_pfm[0])
      else $error("PFM converter left PFM in sleep");
   a_ldo_sleep_lp: assert property (i_sleep && i_ldo_enabled[4] && !s_r.ldo_off[4] && !s_r.ldo_hold[4]
      && !s_r.ldo_pin_one[4] && !s_r.ldo_pin_two[4] |=> o_ldo_on[4] && o_ldo_low_power[4])
      else $error("LDO not low power in sleep");
   a_conv_hold_wins: assert property (i_sleep && s_r.conv_off[1] && s_r.res_hold[1] && i_conv_enabled[1]
      && !s_r.conv_pin_one[1] |=> o_conv_on[1])
      else $error("converter hold did not win");
   a_conv_awake: assert property (!i_sleep && !s_r.conv_pin_one[3]
      |=> o_conv_on[3] == $past(i_conv_enabled[3]))
      else $error("converter sleep-off acted while awake");
   a_ldo_awake: assert property (!i_sleep && !s_r.ldo_pin_one[0] && !s_r.ldo_pin_two[0]
      |=> !o_ldo_low_power[0])
      else $error("unassigned LDO low power while awake");

   // ****************************************
   // Pin control checks
   // ****************************************
   a_pin_high_core: assert property (s_r.conv_pin_one[2] && s_r.pin_one_s2
      |=> o_conv_on[2] == !$past(i_conv_op_off[2]))
      else $error("core b ignored operating setting");
   a_core_lp_pin_low: assert property (s_r.conv_pin_one[2] && !s_r.pin_one_s2 && s_r.res_hold[2]
      && !i_conv_sleep_volt_off[2] |=> o_conv_low_power[2])
      else $error("core b not low power with pin low");
   a_core_off_pin_low: assert property (s_r.conv_pin_one[1] && !s_r.pin_one_s2
      && i_conv_sleep_volt_off[1] |=> !o_conv_on[1] && !o_conv_low_power[1])
      else $error("core a not off with pin low");
   a_ext_volt_sel: assert property (s_r.conv_pin_one[3]
      |=> o_conv_use_sleep_voltage[3] == !$past(s_r.pin_one_s2))
      else $error("external converter voltage select wrong");
   a_io_pin_low: assert property (s_r.conv_pin_one[0] && !s_r.pin_one_s2
      |=> o_conv_on[0] == $past(s_r.res_hold[0]) && o_conv_low_power[0] == $past(s_r.res_hold[0]))
      else $error("IO buck state wrong with pin low");
   a_vs_enable: assert property (!(|s_r.ldo_pin_one) && !(|s_r.conv_pin_one) && !(|s_r.ldo_pin_two)
      |=> !o_vs_i2c_disable)
      else $error("voltage scaling port disabled without assignment");

   // ****************************************
   // Register bank checks
   // ****************************************
   a_pin_one_write: assert property (i_reg_wr && i_reg_addr == sleep_supply_pkg::ADDR_LDO_PIN_ONE
      |=> s_r.ldo_pin_one == $past(i_reg_wdata))
      else $error("pin one LDO write lost");
   a_pin_two_write: assert property (i_reg_wr && i_reg_addr == sleep_supply_pkg::ADDR_LDO_PIN_TWO
      |=> s_r.ldo_pin_two == $past(i_reg_wdata))
      else $error("pin two LDO write lost");
   a_general_clear: assert property (i_general_rst
      |=> s_r.ldo_hold == sleep_supply_pkg::RESET_VALUE && s_r.res_hold == sleep_supply_pkg::RESET_VALUE
      && s_r.conv_off == sleep_supply_pkg::RESET_VALUE) else $error("general reset left a register set");
   a_hold_reserved: assert property (i_reg_rd && i_reg_addr == sleep_supply_pkg::ADDR_RES_HOLD
      |=> o_reg_rdata[3] == 1'h0)
      else $error("reserved hold bit read nonzero");
endmodule : sleep_state_supply_control
`default_nettype wire

/* logic/sleep_supply_pkg.sv */
// Constants for the sleep-state supply control register bank
package sleep_supply_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] ADDR_LDO_HOLD = 8'h41;
   localparam logic [7:0] ADDR_RES_HOLD = 8'h42;
   localparam logic [7:0] ADDR_LDO_SLEEP_OFF = 8'h43;
   localparam logic [7:0] ADDR_CONV_SLEEP_OFF = 8'h44;
   localparam logic [7:0] ADDR_LDO_PIN_ONE = 8'h45;
   localparam logic [7:0] ADDR_CONV_PIN_ONE = 8'h46;
   localparam logic [7:0] ADDR_LDO_PIN_TWO = 8'h47;
   // ****************************************
   // Writable bit masks and reset value
   // ****************************************
   localparam logic [7:0] MASK_FULL = 8'hFF;
   localparam logic [7:0] MASK_RES_HOLD = 8'hF7;
   localparam logic [7:0] MASK_CONV_SLEEP_OFF = 8'h9F;
   localparam logic [7:0] MASK_CONV_PIN_ONE = 8'h1F;
   localparam logic [7:0] RESET_VALUE = 8'h00;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int IO_BIT = 0;
   localparam int CORE_A_BIT = 1;
   localparam int CORE_B_BIT = 2;
   localparam int EXT_BIT = 3;
   localparam int WAKE_SEL_BIT = 7;
   localparam int NUM_LDO = 8;
   localparam int NUM_CONV = 4;
   localparam int NUM_PWM = 3;
endpackage : sleep_supply_pkg

/* verification/host_side_model.sv */
// Host model driving the register strobes and the two control pins
`timescale 1ns/1ns
`default_nettype none
module host_side_model (
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic [7:0] o_addr,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_wdata,
   output logic o_pin_one,
   output logic o_pin_two
);
   initial
   begin
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
      o_pin_one = 1'b0;
      o_pin_two = 1'b0;
   end
   // Idle bus shows the inverse of the last value, never a stale copy
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_clk);
      o_addr = a;
      o_rd = 1'b1;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      @(negedge i_clk);
      d = i_rdata;
   endtask : rd
   task automatic pins(input logic p1, input logic p2);
      @(negedge i_clk);
      o_pin_one = p1;
      o_pin_two = p2;
   endtask : pins
endmodule : host_side_model
`default_nettype wire

/* verification/sleep_state_supply_control_test.sv */
// Self-checking bench for the sleep-state supply control block
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
$display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module sleep_state_supply_control_test;
   logic clk = 1'b0, nrst = 1'b0, grst = 1'b0, sleep = 1'b0, wake = 1'b0;
   logic [7:0] ldo_en = 8'h00, addr, wdata, rdata, ldo_on, ldo_lp;
   logic [3:0] conv_en = 4'h0, op_off = 4'h0, sr_off = 4'h0, conv_on, conv_lp, use_sv;
   logic [2:0] pfm_mode = 3'h0, pfm;
   logic wr, rd, p1, p2, restore, vs_dis;
   int failures = 0, n_compared = 0;
   always #4 clk = ~clk;
   host_side_model u_host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata), .o_pin_one(p1), .o_pin_two(p2));
   sleep_state_supply_control u_dut (.i_clk(clk), .i_nrst(nrst), .i_general_rst(grst),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .i_sleep(sleep),
      .i_wake(wake), .i_mux_ctl_pin_one(p1), .i_mux_ctl_pin_two(p2), .i_ldo_enabled(ldo_en),
      .i_conv_enabled(conv_en), .i_conv_pfm_mode(pfm_mode), .i_conv_op_off(op_off),
      .i_conv_sleep_volt_off(sr_off), .o_reg_rdata(rdata), .o_ldo_on(ldo_on),
      .o_ldo_low_power(ldo_lp), .o_conv_on(conv_on), .o_conv_low_power(conv_lp),
      .o_conv_pfm(pfm), .o_conv_use_sleep_voltage(use_sv), .o_restore_defaults(restore),
      .o_vs_i2c_disable(vs_dis));
   task automatic wrap_up;
      if (failures == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : wrap_up
   task automatic do_reset;
      @(negedge clk);
      nrst = 1'b0;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
   endtask : do_reset
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask : settle
   task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_host.rd(a, d);
      `CHK(d, e)
   endtask : chk_reg
   task automatic pulse_wake(input logic e);
      @(negedge clk);
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      `CHK(restore, e)
      @(negedge clk);
      `CHK(restore, 1'b0)
   endtask : pulse_wake
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      logic [7:0] a;
      do_reset;
      for (a = 8'h41; a <= 8'h47; a++)
         chk_reg(a, 8'h00);
      chk_reg(8'h50, 8'h00);
      u_host.wr(8'h42, 8'hFF);
      u_host.wr(8'h44, 8'hFF);
      u_host.wr(8'h46, 8'hFF);
      u_host.wr(8'h50, 8'hFF);
      chk_reg(8'h42, 8'hF7);
      chk_reg(8'h44, 8'h9F);
      chk_reg(8'h46, 8'h1F);
      chk_reg(8'h50, 8'h00);
      `CHK(vs_dis, 1'b1)
   endtask : t_regs
   task automatic t_sleep;
      do_reset;
      ldo_en = 8'hFF;
      conv_en = 4'hF;
      sleep = 1'b1;
      u_host.wr(8'h43, 8'h0F);
      u_host.wr(8'h41, 8'h03);
      u_host.wr(8'h44, 8'h0F);
      u_host.wr(8'h42, 8'h06);
      settle;
      `CHK(ldo_on, 8'hF3)
      `CHK(ldo_lp, 8'hF0)
      `CHK(conv_on, 4'h6)
      `CHK(pfm, 3'h1)
      `CHK(vs_dis, 1'b0)
      pfm_mode = 3'h7;
      settle;
      `CHK(pfm, 3'h7)
      sleep = 1'b0;
      settle;
      `CHK(ldo_on, 8'hFF)
      `CHK(ldo_lp, 8'h00)
      `CHK(conv_on, 4'hF)
      pfm_mode = 3'h0;
      ldo_en = 8'h00;
      conv_en = 4'h0;
   endtask : t_sleep
   task automatic t_pin_ldo;
      do_reset;
      ldo_en = 8'h01;
      u_host.wr(8'h45, 8'h80);
      u_host.wr(8'h47, 8'h40);
      u_host.wr(8'h41, 8'h40);
      u_host.pins(1'b0, 1'b0);
      settle;
      `CHK(ldo_on, 8'h41)
      `CHK(ldo_lp, 8'h40)
      `CHK(vs_dis, 1'b1)
      u_host.pins(1'b1, 1'b0);
      settle;
      `CHK(ldo_on, 8'hC1)
      u_host.pins(1'b0, 1'b1);
      settle;
      `CHK(ldo_on, 8'h41)
      `CHK(ldo_lp, 8'h00)
      ldo_en = 8'h00;
      settle;
      `CHK(ldo_on, 8'h40)
      u_host.pins(1'b0, 1'b0);
   endtask : t_pin_ldo
   task automatic t_pin_conv;
      do_reset;
      sr_off = 4'h2;
      u_host.wr(8'h46, 8'h0F);
      u_host.wr(8'h42, 8'h07);
      settle;
      `CHK(conv_on, 4'hD)
      `CHK(conv_lp, 4'h5)
      `CHK(use_sv[3:1], 3'h7)
      op_off = 4'h4;
      u_host.pins(1'b1, 1'b0);
      settle;
      `CHK(conv_on, 4'hB)
      `CHK(conv_lp, 4'h0)
      `CHK(use_sv[3:1], 3'h0)
      u_host.pins(1'b0, 1'b0);
      op_off = 4'h0;
      sr_off = 4'h0;
   endtask : t_pin_conv
   task automatic t_resets;
      do_reset;
      u_host.wr(8'h44, 8'h80);
      pulse_wake(1'b1);
      u_host.wr(8'h44, 8'h00);
      pulse_wake(1'b0);
      u_host.wr(8'h43, 8'hAA);
      u_host.wr(8'h45, 8'h55);
      @(negedge clk);
      grst = 1'b1;
      @(negedge clk);
      grst = 1'b0;
      chk_reg(8'h43, 8'h00);
      chk_reg(8'h45, 8'h55);
   endtask : t_resets
   initial
   begin
      #40000;
      failures++;
      wrap_up;
   end
   initial
   begin
      t_regs;
      t_sleep;
      t_pin_ldo;
      t_pin_conv;
      t_resets;
      wrap_up;
   end
endmodule : sleep_state_supply_control_test
`default_nettype wire
